/* File: hdl/led_dim_ctrl.sv */
/*
 * led matrix dimming and shutdown controller: register file on an
 * avalon-mm slave, pwm generation for a 30x6 matrix, de-ghost pull
 * enables and shutdown handling; matrix outputs leave on LINK_CLK.
 * assumes a synchronous active-low reset, an asynchronous shutdown
 * pin and a link clock unrelated to CLOCK.
 */
// Overview of operation
// - only pwm dimming, each led has its own 8-bit value, 256 steps
// - pwm value is a plain binary count of on-steps per period
// - selectable pull-down per scan line, pull-up per sink line
// - a pull resistor is enabled only while its output is off
// - all register contents survive software and hardware shutdown
// - shutdown control bit at zero turns off all current sources
// - registers stay readable and writable in software shutdown
// - shutdown pin low disables outputs; pin high resumes operation
// - shutdown pin rising edge resets bus interface, registers kept
// - function registers remain accessible in hardware shutdown
// - shutdown control is config bit 0, 1 runs, reset value 0
// - pull select fields bits 6:4 and 2:0, code 000 off, reset 101
`include "led_dim_params.svh"

module led_dim_ctrl (
    input  wire logic                   CLOCK,
    input  wire logic                   NRST,
    input  wire logic                   LINK_CLK,
    input  wire logic                   SHUTDOWN_PIN,
    input  wire logic [11:0]            ADDRESS,
    input  wire logic                   READ,
    input  wire logic                   WRITE,
    input  wire logic [31:0]            WRITEDATA,
    input  wire logic [3:0]             BYTEENABLE,
    output logic      [31:0]            READDATA,
    output logic                        WAITREQUEST,
    output logic      [2:0]             SCAN_PULLDOWN_SELECT,
    output logic      [2:0]             SINK_PULLUP_SELECT,
    output logic      [`SCAN_COUNT-1:0] SCAN_LINE_ON,
    output logic      [`SINK_COUNT-1:0] CURRENT_SINK_LINE_ON,
    output logic      [`SCAN_COUNT-1:0] SCAN_PULLDOWN_EN,
    output logic      [`SINK_COUNT-1:0] SINK_PULLUP_EN
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic pwm_hit(input logic [11:0] addr);
        logic [11:0] top;
        top = `PWM_BASE + 12'(`LED_COUNT * 4);
        return (addr >= `PWM_BASE) && (addr < top) && (addr[1:0] == 2'h0);
    endfunction

    function automatic logic [7:0] pwm_index(input logic [11:0] addr);
        logic [11:0] diff;
        diff = addr - `PWM_BASE;
        return diff[9:2];
    endfunction

    // pull is only worth enabling when a resistor is selected
    function automatic logic pull_active(input logic [2:0] sel,
                                         input logic       drive_on);
        return (sel != 3'h0) && !drive_on;
    endfunction

    // ------------------------------------------------------------------
    // core domain
    // ------------------------------------------------------------------
    led_dim_pkg::core_s s_ff;
    led_dim_pkg::core_s nxt_s;
    logic               hw_sd;
    logic               pin_rise;
    logic               run;
    logic               step_ready;
    logic [7:0]         wr_idx;
    logic [7:0]         first_pwm;
    // link state sits here because the core reads its acknowledge
    led_dim_pkg::link_s l_ff;
    led_dim_pkg::link_s nxt_l;

    assign hw_sd      = !s_ff.pin_sync;
    assign pin_rise   = s_ff.pin_sync && !s_ff.pin_prev;
    assign run        = s_ff.cfg[`SHDN_BIT] && !hw_sd;
    assign step_ready = (s_ff.req_tgl == s_ff.ack_sync);
    assign wr_idx     = pwm_index(ADDRESS);
    assign first_pwm  = s_ff.pwm[int'(s_ff.scan_idx) * `SINK_COUNT];

    always_comb begin
        int base;
        base  = int'(s_ff.scan_idx) * `SINK_COUNT;
        nxt_s = s_ff;
        // only the second stage looks at the first
        nxt_s.pin_meta = SHUTDOWN_PIN;
        nxt_s.pin_sync = s_ff.pin_meta;
        nxt_s.pin_prev = s_ff.pin_sync;
        nxt_s.ack_meta = l_ff.req_seen;
        nxt_s.ack_sync = s_ff.ack_meta;

        // bus slave: one wait cycle, then a one-cycle answer
        nxt_s.waitreq = 1'b1;
        if ((READ || WRITE) && s_ff.waitreq) begin
            if (!pin_rise) begin
                nxt_s.waitreq = 1'b0;
                nxt_s.rdata   = 32'h0;
                if (READ) begin
                    if (ADDRESS == `CFG_OFS)
                        nxt_s.rdata = {24'h0, s_ff.cfg};
                    else if (ADDRESS == `PULL_OFS)
                        nxt_s.rdata = {24'h0, s_ff.pull};
                    else if (ADDRESS == `STATUS_OFS)
                        nxt_s.rdata = {30'h0, !run, hw_sd};
                    else if (pwm_hit(ADDRESS))
                        nxt_s.rdata = {24'h0, s_ff.pwm[wr_idx]};
                end
            end
        end else if (WRITE && !s_ff.waitreq && BYTEENABLE[0]) begin
            if (ADDRESS == `CFG_OFS)
                nxt_s.cfg = WRITEDATA[7:0];
            else if (ADDRESS == `PULL_OFS)
                nxt_s.pull = {1'b0, WRITEDATA[6:4], 1'b0, WRITEDATA[2:0]};
            else if (pwm_hit(ADDRESS))
                nxt_s.pwm[wr_idx] = WRITEDATA[7:0];
        end

        // pwm step: next word is built once the link took the last
        if (step_ready) begin
            nxt_s.req_tgl = !s_ff.req_tgl;
            nxt_s.count   = s_ff.count + 8'h01;
            if (s_ff.count == 8'hff)
                nxt_s.scan_idx = (s_ff.scan_idx == 3'(`SCAN_COUNT - 1)) ?
                                 3'h0 : s_ff.scan_idx + 3'h1;
            for (int x = 0; x < `SCAN_COUNT; x++) begin
                nxt_s.word.scan[x]    = run &&
                                        (int'(s_ff.scan_idx) == x);
                nxt_s.word.scan_pd[x] = !hw_sd && pull_active(
                    s_ff.pull[`SCAN_PD_LSB +: 3],
                    nxt_s.word.scan[x]);
            end
            for (int y = 0; y < `SINK_COUNT; y++) begin
                // value n lights the first n of 256 steps
                nxt_s.word.sink[y]    = run && (s_ff.pwm[base + y] >
                                        s_ff.count);
                nxt_s.word.sink_pu[y] = !hw_sd && pull_active(
                    s_ff.pull[`SINK_PU_LSB +: 3],
                    nxt_s.word.sink[y]);
            end
        end
    end

    // shutdown never touches the registers, only the reset does
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            s_ff <= '0;
            s_ff.cfg  <= `CFG_RST;
            s_ff.pull <= `PULL_RST;
            s_ff.pwm  <= {`LED_COUNT{`PWM_RST}};
            s_ff.waitreq <= 1'b1;
            // pin sync starts at its idle level so reset fakes no rise
            s_ff.pin_meta <= 1'b1;
            s_ff.pin_sync <= 1'b1;
            s_ff.pin_prev <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign READDATA             = s_ff.rdata;
    assign WAITREQUEST          = s_ff.waitreq;
    assign SCAN_PULLDOWN_SELECT = s_ff.pull[`SCAN_PD_LSB +: 3];
    assign SINK_PULLUP_SELECT   = s_ff.pull[`SINK_PU_LSB +: 3];

    // ------------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------------

    // word is stable while the toggle is in flight, so sampling is safe
    always_comb begin
        nxt_l          = l_ff;
        nxt_l.rst_meta = NRST;
        nxt_l.rst_sync = l_ff.rst_meta;
        nxt_l.req_meta = s_ff.req_tgl;
        nxt_l.req_sync = l_ff.req_meta;
        if (l_ff.req_sync != l_ff.req_seen) begin
            nxt_l.req_seen = l_ff.req_sync;
            nxt_l.out      = s_ff.word;
        end
    end

    always_ff @(posedge LINK_CLK) begin
        if (!l_ff.rst_sync) begin
            l_ff          <= '0;
            l_ff.rst_meta <= nxt_l.rst_meta;
            l_ff.rst_sync <= nxt_l.rst_sync;
        end else begin
            l_ff <= nxt_l;
        end
    end

    assign SCAN_LINE_ON         = l_ff.out.scan;
    assign CURRENT_SINK_LINE_ON = l_ff.out.sink;
    assign SCAN_PULLDOWN_EN     = l_ff.out.scan_pd;
    assign SINK_PULLUP_EN       = l_ff.out.sink_pu;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_sw_blank: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (step_ready && !s_ff.cfg[`SHDN_BIT]) |=> (s_ff.word.sink == '0))
        else $error("sinks on during software shutdown");

    chk_hw_blank: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (step_ready && hw_sd) |=>
            (s_ff.word.sink == '0) && (s_ff.word.scan == '0) &&
            (s_ff.word.sink_pu == '0))
        else $error("outputs active during hardware shutdown");

    chk_pull_off: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        ((s_ff.word.sink & s_ff.word.sink_pu) == '0) &&
        ((s_ff.word.scan & s_ff.word.scan_pd) == '0))
        else $error("pull enabled on a driven line");

    chk_regs_kept: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (s_ff.waitreq || !WRITE) |=>
            $stable(s_ff.cfg) && $stable(s_ff.pull))
        else $error("register changed without a write");

    chk_rise_abort: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (pin_rise && s_ff.waitreq) |=> s_ff.waitreq)
        else $error("access answered across shutdown pin rise");

    chk_answer_time: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        ((READ || WRITE) && s_ff.waitreq && !pin_rise) |=>
            !s_ff.waitreq ##1 s_ff.waitreq)
        else $error("bus answer not exactly one cycle late");

    chk_write_applies: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (!s_ff.waitreq && WRITE && BYTEENABLE[0] && pwm_hit(ADDRESS)) |=>
            (s_ff.pwm[$past(wr_idx)] == $past(WRITEDATA[7:0])))
        else $error("pwm write not stored");

    chk_pwm_step: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (step_ready && run) |=>
            (s_ff.word.sink[0] == ($past(first_pwm) > $past(s_ff.count))))
        else $error("sink state does not follow pwm compare");

    chk_pull_code: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (s_ff.pull[7] == 1'b0) && (s_ff.pull[3] == 1'b0))
        else $error("reserved pull bits set");

    chk_pull_write: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (!s_ff.waitreq && WRITE && BYTEENABLE[0] && (ADDRESS == `PULL_OFS))
            |=> (s_ff.pull[6:4] == $past(WRITEDATA[6:4])) &&
                (s_ff.pull[2:0] == $past(WRITEDATA[2:0])))
        else $error("pull write not stored");

    chk_cfg_write: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (!s_ff.waitreq && WRITE && BYTEENABLE[0] && (ADDRESS == `CFG_OFS))
            |=> (s_ff.cfg == $past(WRITEDATA[7:0])))
        else $error("config write not stored");

    chk_pwm_kept: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (s_ff.waitreq || !WRITE) |=> $stable(s_ff.pwm))
        else $error("pwm value changed without a write");

    chk_masked_write: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (!s_ff.waitreq && WRITE && !BYTEENABLE[0]) |=>
            $stable(s_ff.cfg) && $stable(s_ff.pull) && $stable(s_ff.pwm))
        else $error("write without lane 0 changed a register");

    chk_rdata_width: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (s_ff.rdata[31:8] == 24'h0))
        else $error("read data above byte lane 0");

    chk_wait_cause: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        !s_ff.waitreq |-> ($past(READ) || $past(WRITE)))
        else $error("answer without a request");

    chk_hw_access: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        ((READ || WRITE) && s_ff.waitreq && !pin_rise && hw_sd) |=>
            !s_ff.waitreq)
        else $error("access refused in hardware shutdown");

    chk_scan_onehot: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (step_ready && run) |=> $onehot(s_ff.word.scan))
        else $error("not exactly one scan line in a step");

    chk_scan_idle: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (step_ready && !run) |=> (s_ff.word.scan == '0))
        else $error("scan line driven while blanked");

    chk_sink_pullup: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (step_ready && !hw_sd && (s_ff.pull[2:0] != 3'h0)) |=>
            (s_ff.word.sink_pu == ~s_ff.word.sink))
        else $error("sink pull-up missing on an off line");

    chk_scan_pulldown: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (step_ready && !hw_sd && (s_ff.pull[6:4] != 3'h0)) |=>
            (s_ff.word.scan_pd == ~s_ff.word.scan))
        else $error("scan pull-down missing on an off line");

    chk_no_pullup: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (step_ready && (s_ff.pull[2:0] == 3'h0)) |=>
            (s_ff.word.sink_pu == '0))
        else $error("sink pull-up on with code zero");

    chk_no_pulldown: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (step_ready && (s_ff.pull[6:4] == 3'h0)) |=>
            (s_ff.word.scan_pd == '0))
        else $error("scan pull-down on with code zero");

    chk_count_step: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        step_ready |=> (s_ff.count == $past(s_ff.count) + 8'h01))
        else $error("pwm count did not advance by one");

    chk_scan_advance: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (step_ready && (s_ff.count != 8'hff)) |=>
            $stable(s_ff.scan_idx))
        else $error("scan line moved before the count wrapped");

    chk_scan_range: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        (s_ff.scan_idx < 3'(`SCAN_COUNT)))
        else $error("scan index out of range");

    chk_word_hold: assert property (
        @(posedge CLOCK) disable iff (!NRST)
        !step_ready |=> $stable(s_ff.word))
        else $error("drive word changed while in flight");

endmodule

/* File: hdl/led_dim_params.svh */
/*
 * constants of the led matrix dimming and shutdown controller:
 * register offsets, field positions, reset values and matrix size.
 * assumes inclusion by bare name from the package and the top module.
 */
`ifndef LED_DIM_PARAMS_SVH
`define LED_DIM_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets on the avalon slave
// ----------------------------------------------------------------------
`define CFG_OFS       12'h000
`define PULL_OFS      12'h004
`define STATUS_OFS    12'h008
`define PWM_BASE      12'h400

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define SHDN_BIT      0
`define SCAN_PD_LSB   4
`define SINK_PU_LSB   0
`define CFG_RST       8'h00
`define PULL_RST      8'h55
`define PWM_RST       8'h00

// ----------------------------------------------------------------------
// matrix size
// ----------------------------------------------------------------------
`define SCAN_COUNT    6
`define SINK_COUNT    30
`define LED_COUNT     180

`endif

/* File: hdl/led_dim_pkg.sv */
/*
 * types of the led matrix dimming and shutdown controller.
 * assumes led_dim_params.svh is on the include path.
 */
`include "led_dim_params.svh"

package led_dim_pkg;

    // ------------------------------------------------------------------
    // matrix drive word passed to the link domain
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`SCAN_COUNT-1:0] scan;
        logic [`SINK_COUNT-1:0] sink;
        logic [`SCAN_COUNT-1:0] scan_pd;
        logic [`SINK_COUNT-1:0] sink_pu;
    } matrix_s;

    // ------------------------------------------------------------------
    // core domain state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                      pin_meta;
        logic                      pin_sync;
        logic                      pin_prev;
        logic [7:0]                cfg;
        logic [7:0]                pull;
        logic [`LED_COUNT-1:0][7:0] pwm;
        logic                      waitreq;
        logic [31:0]               rdata;
        logic [7:0]                count;
        logic [2:0]                scan_idx;
        logic                      req_tgl;
        logic                      ack_meta;
        logic                      ack_sync;
        matrix_s                   word;
    } core_s;

    // ------------------------------------------------------------------
    // link domain state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic    rst_meta;
        logic    rst_sync;
        logic    req_meta;
        logic    req_sync;
        logic    req_seen;
        matrix_s out;
    } link_s;

endpackage

/* File: sim/led_host.sv */
/*
 * host model: avalon-mm master that reads and writes the registers
 * and rewrites pwm values to breathe an led.
 * assumes it shares the slave's clock and is called just after an edge.
 */
module led_host (
    input  wire logic        clock,
    input  wire logic        waitrequest,
    output logic      [11:0] address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // breathing steps
    // ------------------------------------------------------------------
    // head of the 32-step table, the size that suits a one second cycle
    logic [7:0] g32 [8] = '{8'h00, 8'h01, 8'h02, 8'h04,
                            8'h06, 8'h0a, 8'h0d, 8'h12};
    // head of the 64-step table, for the slower two second cycle
    logic [7:0] g64 [8] = '{8'h00, 8'h01, 8'h02, 8'h03,
                            8'h04, 8'h05, 8'h06, 8'h07};

    initial begin
        address    = 12'h000;
        read       = 1'b0;
        write      = 1'b0;
        writedata  = 32'h0;
        byteenable = 4'h0;
    end

    // ------------------------------------------------------------------
    // one bus cycle
    // ------------------------------------------------------------------
    // the extra edge at the end keeps two cycles from sharing a step
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        write      <= w;
        read       <= !w;
        @(posedge clock);
        // no cycle count is assumed; only the bench watchdog ends a hang
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic breathe(input logic [11:0] a);
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, a, {24'h0, g32[i]}, 4'h1);
        end
    endtask

    task automatic breathe_fine(input logic [11:0] a);
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, a, {24'h0, g64[i]}, 4'h1);
        end
    endtask
endmodule

/* File: sim/led_matrix_dimming_shutdown_ctrl_bench.sv */
/*
 * bench of the led matrix dimming and shutdown controller.
 * assumes the register map and timing of the designer's hand-over.
 */
`include "led_dim_params.svh"

module led_matrix_dimming_shutdown_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clock = 1'b0;
    logic                   link_clk = 1'b0;
    logic                   nrst = 1'b0;
    logic                   shutdown_pin = 1'b1;
    logic [11:0]            address;
    logic                   read;
    logic                   write;
    logic [31:0]            writedata;
    logic [3:0]             byteenable;
    logic [31:0]            readdata;
    logic                   waitrequest;
    logic [2:0]             scan_sel;
    logic [2:0]             sink_sel;
    logic [`SCAN_COUNT-1:0] scan_on;
    logic [`SINK_COUNT-1:0] sink_on;
    logic [`SCAN_COUNT-1:0] pd_en;
    logic [`SINK_COUNT-1:0] pu_en;
    logic [31:0]            exp_q [$];
    logic [7:0]             v;
    bit                     live, blank, hw, zchk;
    int                     n_mismatch, check_count, on0;

    initial forever #5 clock = ~clock;
    // odd offset keeps link edges apart from core edges
    initial begin
        #2;
        forever #7.5 link_clk = ~link_clk;
    end

    led_dim_ctrl u_led_dim_ctrl (
        .CLOCK(clock), .NRST(nrst), .LINK_CLK(link_clk),
        .SHUTDOWN_PIN(shutdown_pin), .ADDRESS(address), .READ(read),
        .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(byteenable),
        .READDATA(readdata), .WAITREQUEST(waitrequest),
        .SCAN_PULLDOWN_SELECT(scan_sel), .SINK_PULLUP_SELECT(sink_sel),
        .SCAN_LINE_ON(scan_on), .CURRENT_SINK_LINE_ON(sink_on),
        .SCAN_PULLDOWN_EN(pd_en), .SINK_PULLUP_EN(pu_en));

    led_host u_led_host (
        .clock(clock), .waitrequest(waitrequest), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable));

    // ------------------------------------------------------------------
    // compares and closing
    // ------------------------------------------------------------------
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: data %h not %h", $time, got, exp);
        end
    endtask

    task automatic cmp_line(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: lines %h not %h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        u_led_host.acc(1'b1, a, d, be);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_led_host.acc(1'b0, a, 32'h0, 4'hf);
    endtask

    // ------------------------------------------------------------------
    // monitors
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (read && waitrequest === 1'b0) begin
            cmp_rd(readdata, exp_q.pop_front());
        end
    end

    // blank and hw are set well after the mode change and cleared before it reaches the outputs; outputs lag a few edges
    always @(posedge link_clk) begin
        if (live) begin
            cmp_line({pu_en & sink_on, pd_en & scan_on}, 36'h0);
            if (blank) cmp_line({6'h0, sink_on}, 36'h0);
            if (hw) cmp_line({pu_en, pd_en}, 36'h0);
            if (zchk) begin
                cmp_line({34'h0, sink_on[1], pu_en[1]}, 36'h1);
                cmp_line({30'h0, pd_en ^ scan_on}, 36'h3f);
                if (sink_on[0] === 1'b1) on0++;
            end
        end
    end

    initial begin
        #500000;
        n_mismatch++;
        conclude;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h91c8cf1a));
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        live = 1;
        blank = 1;
        rd(`CFG_OFS, 32'h0);
        rd(`PULL_OFS, 32'h55);
        rd(12'h6cc, 32'h0);
        v = 8'($urandom);
        wr(12'h6cc, {24'h0, v}, 4'h1);
        rd(12'h6cc, {24'h0, v});
        wr(12'h6cc, {24'h0, ~v}, 4'h0);
        rd(12'h6cc, {24'h0, v});
        rd(12'h300, 32'h0);
        wr(`PULL_OFS, 32'hff, 4'h1);
        rd(`PULL_OFS, 32'h77);
        cmp_rd({26'h0, scan_sel, sink_sel}, 32'h3f);
        u_led_host.breathe(`PWM_BASE);
        rd(`PWM_BASE, 32'h12);
        u_led_host.breathe_fine(12'h408);
        rd(12'h408, 32'h7);
        wr(`CFG_OFS, 32'h1, 4'h1);
        blank = 0;
        zchk = 1;
        // long enough for every scan line to pass once
        repeat (15000) @(posedge clock);
        zchk = 0;
        cmp_rd({31'h0, on0 != 0}, 32'h1);
        shutdown_pin <= 1'b0;
        repeat (20) @(posedge clock);
        blank = 1;
        hw = 1;
        rd(`STATUS_OFS, 32'h3);
        wr(`PWM_BASE, 32'hff, 4'h1);
        rd(`PWM_BASE, 32'hff);
        wr(`CFG_OFS, 32'h1, 4'h1);
        wr(`PULL_OFS, 32'h77, 4'h1);
        hw = 0;
        blank = 0;
        shutdown_pin <= 1'b1;
        // the read lands on the synced rise and must be taken afresh
        repeat (2) @(posedge clock);
        rd(`CFG_OFS, 32'h1);
        rd(`PULL_OFS, 32'h77);
        rd(`PWM_BASE, 32'hff);
        rd(12'h6cc, {24'h0, v});
        conclude;
    end
endmodule
